// >>> cpmc_top.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
// Purpose: charge pump mode register and enable decision
// Assumes: comparator and pump-ready come from the analog side
// Notes:   converter enable arrives on the core clock
module cpmc_top
    import cpmc_pkg::*;
(
    input  wire logic                       clock,
    input  wire logic                       resetn,
    input  wire logic [cpmc_pkg::CPMC_AW-1:0] addr,
    input  wire logic [7:0]                 wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic      [7:0]                 rdata,
    input  wire logic                       supply_above_threshold,
    input  wire logic                       pump_ready_raw,
    input  wire logic                       adc_enable,
    output logic                            pump_enable
);
    import cpmc_pkg::*;

    // address decode compares against an 8-bit offset
    if (CPMC_AW < 8) begin : g_aw_check
        $error("address width too narrow for control offset");
    end

    cpmc_sync_if sif ();

    cpmc_sync u_sync (
        .clock      (clock),
        .resetn     (resetn),
        .above_raw  (supply_above_threshold),
        .steady_raw (pump_ready_raw),
        .so         (sif.prod)
    );

    cpmc_mode_t  mode_q;
    cpmc_mode_t  mode_d;
    logic        pump_q;
    logic        pump_d;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;
    logic        sel;
    logic        flag_steady;

    assign sel = (addr == CPMC_CTRL_OFS);
    // analog ready can lag switch-off; only report steady while enabled
    assign flag_steady = sif.steady & pump_q;

    function automatic logic pump_want(cpmc_mode_t m, logic above, logic adc_on);
        unique case (m)
            CPMC_FORCED: pump_want = 1'b1;
            CPMC_SUPPLY: pump_want = !above;
            CPMC_PERIPH: pump_want = adc_on && !above;
            CPMC_OFF:    pump_want = 1'b0;
        endcase
    endfunction : pump_want

    always_comb begin
        mode_d  = mode_q;
        rdata_d = CPMC_RD_ZERO;
        if (wr && sel) begin
            // only bits 7:6 stored; flags and 5:2 dropped
            mode_d = cpmc_mode_t'(wdata[CPMC_MODE_HI:CPMC_MODE_LO]);
        end
        if (rd && sel) begin
            rdata_d[CPMC_MODE_HI:CPMC_MODE_LO] = mode_q;
            rdata_d[CPMC_THR_BIT] = sif.above_thr;
            rdata_d[CPMC_RDY_BIT] = flag_steady;
        end
        pump_d = pump_want(mode_q, sif.above_thr, adc_enable);
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mode_q  <= cpmc_mode_t'(CPMC_MODE_RST);
            pump_q  <= 1'b0;
            rdata_q <= CPMC_RD_ZERO;
        end else begin
            mode_q  <= mode_d;
            pump_q  <= pump_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata       = rdata_q;
    assign pump_enable = pump_q;

    AST_FORCED_ON: assert property (@(posedge clock) disable iff (!resetn)
        mode_q == CPMC_FORCED |=> pump_q)
        else $error("forced mode but pump off");
    AST_SUPPLY_LOW: assert property (@(posedge clock) disable iff (!resetn)
        (mode_q == CPMC_SUPPLY && !sif.above_thr) |=> pump_q)
        else $error("supply mode low supply pump off");
    AST_SUPPLY_HIGH: assert property (@(posedge clock) disable iff (!resetn)
        (mode_q == CPMC_SUPPLY && sif.above_thr) |=> !pump_q)
        else $error("supply mode high supply pump on");
    AST_PERIPH_IDLE: assert property (@(posedge clock) disable iff (!resetn)
        (mode_q == CPMC_PERIPH && !adc_enable) |=> !pump_q)
        else $error("periph mode pump on without converter");
    AST_PERIPH_ON: assert property (@(posedge clock) disable iff (!resetn)
        (mode_q == CPMC_PERIPH && adc_enable && !sif.above_thr) |=> pump_q)
        else $error("periph mode low supply pump off");
    AST_OFF_MODE: assert property (@(posedge clock) disable iff (!resetn)
        (wr && sel && wdata[7:6] == 2'h0) |=> ##1 !pump_q)
        else $error("mode 00 written but pump still on");
    AST_RD_LAYOUT: assert property (@(posedge clock) disable iff (!resetn)
        rd |=> rdata[5:2] == 4'h0)
        else $error("unused bits read nonzero");
    AST_RD_MODE: assert property (@(posedge clock) disable iff (!resetn)
        (rd && sel) |=> rdata[7:6] == $past(mode_q))
        else $error("mode field readback wrong");
    AST_RDY_OFF: assert property (@(posedge clock) disable iff (!resetn)
        (rd && sel && !pump_q) |=> !rdata[0])
        else $error("ready flag set with pump off");
    AST_THR_FLAG: assert property (@(posedge clock) disable iff (!resetn)
        (rd && sel) |=> rdata[1] == $past(sif.above_thr))
        else $error("threshold flag mismatch");
    AST_OFF_HOLD: assert property (@(posedge clock) disable iff (!resetn)
        mode_q == CPMC_OFF |=> !pump_q)
        else $error("off mode but pump on");
    AST_PERIPH_HIGH: assert property (@(posedge clock) disable iff (!resetn)
        (mode_q == CPMC_PERIPH && sif.above_thr) |=> !pump_q)
        else $error("periph mode high supply pump on");
    AST_PERIPH_GATE: assert property (@(posedge clock) disable iff (!resetn)
        (mode_q == CPMC_PERIPH && !sif.above_thr) |=> pump_q == $past(adc_enable))
        else $error("periph mode pump not following converter enable");
    AST_MODE_HOLD: assert property (@(posedge clock) disable iff (!resetn)
        !(wr && sel) |=> mode_q == $past(mode_q))
        else $error("mode changed without write");
    AST_MODE_WRITE: assert property (@(posedge clock) disable iff (!resetn)
        (wr && sel) |=> logic'(mode_q[1]) == $past(wdata[CPMC_MODE_HI]))
        else $error("mode upper bit not stored");
    AST_RD_IDLE: assert property (@(posedge clock) disable iff (!resetn)
        !(rd && sel) |=> rdata == CPMC_RD_ZERO)
        else $error("read data nonzero without selected read");
    AST_RDY_ON: assert property (@(posedge clock) disable iff (!resetn)
        (rd && sel && pump_q && sif.steady) |=> rdata[CPMC_RDY_BIT])
        else $error("ready flag clear with pump steady");
    // no disable here: reset values must show while reset is held
    AST_RST_STATE: assert property (@(posedge clock)
        !resetn |-> (mode_q == CPMC_OFF && !pump_q && rdata == CPMC_RD_ZERO))
        else $error("state not at reset values during reset");
endmodule : cpmc_top

// >>> cpmc_pkg.sv
// Purpose: constants for the charge pump mode control block
// Assumes: byte-wide register port, one clock at 125 MHz
// Notes:   register index is the printed offset
package cpmc_pkg;
    localparam int          CPMC_AW          = 8;
    localparam logic [7:0]  CPMC_CTRL_OFS    = 8'h9a;
    localparam int          CPMC_MODE_HI     = 7;
    localparam int          CPMC_MODE_LO     = 6;
    localparam int          CPMC_THR_BIT     = 1;
    localparam int          CPMC_RDY_BIT     = 0;
    localparam logic [1:0]  CPMC_MODE_RST    = 2'h0;
    localparam logic [7:0]  CPMC_RD_ZERO     = 8'h00;

    typedef enum logic [1:0] {
        CPMC_OFF    = 2'h0,
        CPMC_PERIPH = 2'h1,
        CPMC_SUPPLY = 2'h2,
        CPMC_FORCED = 2'h3
    } cpmc_mode_t;
endpackage : cpmc_pkg

// >>> cpmc_sync_if.sv
`timescale 1ns/1ns
// Purpose: carries synchronised analog levels to the top
// Assumes: one clock domain
// Notes:   producer is the synchroniser
interface cpmc_sync_if;
    logic above_thr;
    logic steady;
    modport prod (output above_thr, output steady);
    modport cons (input  above_thr, input  steady);
endinterface : cpmc_sync_if

// >>> cpmc_sync.sv
`timescale 1ns/1ns
// Purpose: two-flop synchroniser for the analog status levels
// Assumes: inputs are slow levels
// Notes:   first stage feeds only the second
module cpmc_sync (
    input  wire logic  clock,
    input  wire logic  resetn,
    input  wire logic  above_raw,
    input  wire logic  steady_raw,
    cpmc_sync_if.prod  so
);
    logic [1:0] s1_q;
    logic [1:0] s1_d;
    logic [1:0] s2_q;
    logic [1:0] s2_d;

    always_comb begin
        s1_d = {above_raw, steady_raw};
        s2_d = s1_q;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s1_q <= 2'h0;
            s2_q <= 2'h0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end

    assign so.above_thr = s2_q[1];
    assign so.steady    = s2_q[0];
endmodule : cpmc_sync

// >>> cpmc_analog_model.sv
// Purpose: analog side model, supply comparator and pump settling
// Assumes: supply level is set by the bench
// Notes:   ready drops at once when the pump stops, kinder than silicon
`timescale 1ns/1ns
module cpmc_analog_model #(
    parameter int SETTLE = 4
) (
    input  wire logic clock,
    input  wire logic vdd_high,
    input  wire logic pump_enable,
    output logic      supply_above_threshold,
    output logic      pump_ready_raw
);
    int cnt = 0;
    assign supply_above_threshold = vdd_high;
    // pump needs a few cycles running before it is steady
    always @(posedge clock) begin
        cnt <= pump_enable ? ((cnt < SETTLE) ? cnt + 1 : cnt) : 0;
    end
    assign pump_ready_raw = pump_enable && (cnt >= SETTLE);
endmodule : cpmc_analog_model

// >>> tb.sv
// Purpose: register-level test of the charge pump mode control
// Assumes: analog side from the partner model
// Notes:   fixed settle waits cover sync plus pump settling
`timescale 1ns/1ns
module tb;
    import cpmc_pkg::*;
    logic       clock = 0, resetn = 0, wr = 0, rd = 0, vdd_high = 1, adc_enable = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
    logic       pump_enable, supply_above_threshold, pump_ready_raw, e;
    logic [1:0] m;
    int         err_total = 0;
    int         checks = 0;
    initial forever #4 clock = ~clock;
    cpmc_top cpmc_top_inst (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .supply_above_threshold(supply_above_threshold),
        .pump_ready_raw(pump_ready_raw), .adc_enable(adc_enable), .pump_enable(pump_enable));
    cpmc_analog_model cpmc_analog_model_inst (.clock(clock), .vdd_high(vdd_high),
        .pump_enable(pump_enable), .supply_above_threshold(supply_above_threshold),
        .pump_ready_raw(pump_ready_raw));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wr_reg
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    task automatic tally_and_finish;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        rd_reg(CPMC_CTRL_OFS, v);
        check(v, 8'h00);
        // supply toggles fastest so every mode sees both edges of it
        for (int i = 0; i < 16; i++) begin
            m = i[3:2];
            vdd_high   <= i[0];
            adc_enable <= i[1];
            wr_reg(CPMC_CTRL_OFS, {m, 6'h3f});
            repeat (10) @(posedge clock);
            e = (m == 2'h3) || (m == 2'h2 && !i[0]) || (m == 2'h1 && i[1] && !i[0]);
            #1;
            check({7'h00, pump_enable}, {7'h00, e});
            rd_reg(CPMC_CTRL_OFS, v);
            check(v, {m, 4'h0, i[0], e});
        end
        wr_reg(8'h9b, 8'h00);
        rd_reg(8'h9b, v);
        check(v, 8'h00);
        rd_reg(CPMC_CTRL_OFS, v);
        check(v, 8'hc3);
        wr_reg(CPMC_CTRL_OFS, 8'h00);
        repeat (3) @(posedge clock);
        #1;
        check({7'h00, pump_enable}, 8'h00);
        // converter switched off while pump runs in gated mode
        vdd_high   <= 1'b0;
        adc_enable <= 1'b1;
        wr_reg(CPMC_CTRL_OFS, 8'h40);
        repeat (10) @(posedge clock);
        #1;
        check({7'h00, pump_enable}, 8'h01);
        adc_enable <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        check({7'h00, pump_enable}, 8'h00);
        tally_and_finish();
    end
endmodule : tb
